// ==== hw/odp_pkg.sv ====
// Shared constants and types for the output delay and protection block.
package odp_pkg;
  // ----------------------------------------
  // Channels and timing
  // ----------------------------------------
  localparam int NUM_CH = 2;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_MAX_MS = 10000;
  localparam int DLY_W = 14;
  localparam logic [DLY_W-1:0] DELAY_MAX = DLY_W'(DELAY_MAX_MS);
  localparam logic [DLY_W-1:0] DELAY_RST = 14'h0000;
  localparam logic DLY_EN_RST = 1'b0;
  localparam logic REQ_RST = 1'b0;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] CH_STRIDE = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_RISE = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_FALL = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_STAT = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_PCLR = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 6'h2c;
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_DLY_EN_BIT = 1;
  localparam int STAT_QSUM_BIT = 7;
  localparam int STAT_OUT_BIT = 8;
  localparam int STAT_BUSY_BIT = 9;
  localparam int STAT_CODE_LSB = 16;
  localparam int IRQ_W = 2 * NUM_CH;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // ----------------------------------------
  // Fault flags and trip codes
  // ----------------------------------------
  localparam int FAULT_W = 5;
  localparam int FLT_OC = 0;
  localparam int FLT_OV = 1;
  localparam int FLT_OT = 2;
  localparam int FLT_RVS = 3;
  localparam int FLT_OPS = 4;
  typedef enum logic [2:0] {
    TRIP_NONE = 3'h0,
    TRIP_OC = 3'h1,
    TRIP_OV = 3'h2,
    TRIP_OT = 3'h3,
    TRIP_RVS = 3'h4,
    TRIP_OPS = 3'h5
  } odp_trip_e;
  typedef enum logic [3:0] {
    CS_OFF = 4'h1,
    CS_WAIT_ON = 4'h2,
    CS_ON = 4'h4,
    CS_WAIT_OFF = 4'h8
  } odp_chst_e;
endpackage : odp_pkg

// ==== hw/odp_ms_tick.sv ====
// Restartable one-millisecond tick generator.
`timescale 1ns/1ps
`default_nettype none
module odp_ms_tick
  import odp_pkg::*;
#(
  parameter int CYC = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Control and tick.
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] cnt;

  // Restarting aligns the first tick a full period after the request.
  always_ff @(posedge mclk) begin
    if (sys_rst || restart || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  assign tick = (cnt == LAST);
endmodule : odp_ms_tick
`default_nettype wire

// ==== hw/odp_chan.sv ====
// One channel: output switching sequencer and fault latch.
`timescale 1ns/1ps
`default_nettype none
module odp_chan
  import odp_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Settings.
  input wire logic want_on,
  input wire logic dly_en,
  input wire logic [DLY_W-1:0] rise_ms,
  input wire logic [DLY_W-1:0] fall_ms,
  // Timing.
  input wire logic tick,
  output logic restart,
  // Protection.
  input wire logic [FAULT_W-1:0] trip,
  input wire logic prot_clr,
  output logic [FAULT_W-1:0] flags,
  output logic qsum,
  output logic [2:0] trip_code,
  output logic trip_evt,
  // Output state.
  output logic out_on,
  output logic busy,
  output logic switch_evt
);
  odp_chst_e state;
  odp_chst_e next_state;
  logic [DLY_W-1:0] ms_cnt;
  logic [DLY_W-1:0] ms_next;
  logic faulted;
  logic next_out;

  assign faulted = |flags;
  assign ms_next = ms_cnt + 14'h0001;
  assign next_out = (next_state == CS_ON) || (next_state == CS_WAIT_OFF);
  assign restart = (next_state != state);

  always_comb begin
    next_state = state;
    case (state)
      CS_OFF: begin
        if (want_on && !faulted) begin
          next_state = (dly_en && rise_ms != DELAY_RST) ? CS_WAIT_ON : CS_ON;
        end
      end
      CS_WAIT_ON: begin
        if (!want_on || faulted) begin
          next_state = CS_OFF;
        end else if (!dly_en || (tick && ms_next >= rise_ms)) begin
          next_state = CS_ON;
        end
      end
      CS_ON: begin
        if (faulted) begin
          next_state = CS_OFF;
        end else if (!want_on) begin
          next_state = (dly_en && fall_ms != DELAY_RST) ? CS_WAIT_OFF : CS_OFF;
        end
      end
      CS_WAIT_OFF: begin
        if (faulted) begin
          next_state = CS_OFF;
        end else if (want_on) begin
          next_state = CS_ON;
        end else if (!dly_en || (tick && ms_next >= fall_ms)) begin
          next_state = CS_OFF;
        end
      end
      default: next_state = CS_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= CS_OFF;
      out_on <= 1'b0;
      busy <= 1'b0;
      switch_evt <= 1'b0;
    end else begin
      state <= next_state;
      out_on <= next_out;
      busy <= (next_state == CS_WAIT_ON) || (next_state == CS_WAIT_OFF);
      switch_evt <= (next_out != out_on);
    end
  end

  // Millisecond count restarts on every state change.
  always_ff @(posedge mclk) begin
    if (sys_rst || restart) begin
      ms_cnt <= '0;
    end else if (tick) begin
      ms_cnt <= ms_next;
    end
  end

  // A trip in the clearing cycle survives the clear.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags <= '0;
      qsum <= 1'b0;
      trip_evt <= 1'b0;
    end else begin
      flags <= (flags & ~{FAULT_W{prot_clr}}) | trip;
      qsum <= (qsum & ~prot_clr) | (|trip[FLT_RVS:FLT_OC]);
      trip_evt <= |(trip & ~flags);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trip_code <= TRIP_NONE;
    end else if (flags[FLT_OC]) begin
      trip_code <= TRIP_OC;
    end else if (flags[FLT_OV]) begin
      trip_code <= TRIP_OV;
    end else if (flags[FLT_OT]) begin
      trip_code <= TRIP_OT;
    end else if (flags[FLT_RVS]) begin
      trip_code <= TRIP_RVS;
    end else if (flags[FLT_OPS]) begin
      trip_code <= TRIP_OPS;
    end else begin
      trip_code <= TRIP_NONE;
    end
  end
endmodule : odp_chan
`default_nettype wire

// ==== hw/odp_top.sv ====
// Output delay and protection block with AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Rising delay holds output off until elapsed.
// - Falling delay holds output on until elapsed.
// - Delays zero to ten seconds, millisecond steps.
// - Delay enable gates both delays, default off.
// - Rising and falling delays stored independently.
// - Protection clear resets faults and summary bit.
// - Trip query gives one of six codes.
// - Operations per channel; unspecified means channel one.
// - Reversed sense latched like other faults.
module odp_top
  import odp_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // AXI4-Lite write address.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protection trip pins, one bit per channel.
  input wire logic [NUM_CH-1:0] over_current_trip,
  input wire logic [NUM_CH-1:0] over_voltage_trip,
  input wire logic [NUM_CH-1:0] over_temp_trip,
  input wire logic [NUM_CH-1:0] reversed_sense_fault,
  input wire logic [NUM_CH-1:0] open_sense_fault,
  // Channel outputs and interrupt.
  output logic [NUM_CH-1:0] chan_out,
  output logic irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [NUM_CH*FAULT_W-1:0] trip_raw;
  logic [NUM_CH*FAULT_W-1:0] trip_meta;
  logic [NUM_CH*FAULT_W-1:0] trip_sync;
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] w_mask;
  logic wr_fire;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_word;
  logic [NUM_CH-1:0] ctrl_req;
  logic [NUM_CH-1:0] ctrl_dly_en;
  logic [NUM_CH-1:0][DLY_W-1:0] rise_ms;
  logic [NUM_CH-1:0][DLY_W-1:0] fall_ms;
  logic [NUM_CH-1:0] prot_clr;
  logic [NUM_CH-1:0] ms_tick;
  logic [NUM_CH-1:0] ms_restart;
  logic [NUM_CH-1:0][FAULT_W-1:0] flags;
  logic [NUM_CH-1:0] qsum;
  logic [NUM_CH-1:0][2:0] trip_code;
  logic [NUM_CH-1:0] trip_evt;
  logic [NUM_CH-1:0] busy;
  logic [NUM_CH-1:0] switch_evt;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic pclr_hit;
  logic pclr_idx;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_pins
    assign trip_raw[c*FAULT_W+FLT_OC] = over_current_trip[c];
    assign trip_raw[c*FAULT_W+FLT_OV] = over_voltage_trip[c];
    assign trip_raw[c*FAULT_W+FLT_OT] = over_temp_trip[c];
    assign trip_raw[c*FAULT_W+FLT_RVS] = reversed_sense_fault[c];
    assign trip_raw[c*FAULT_W+FLT_OPS] = open_sense_fault[c];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trip_meta <= '0;
      trip_sync <= '0;
    end else begin
      trip_meta <= trip_raw;
      trip_sync <= trip_meta;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready = !w_have && !s_axi_bvalid;
  assign wr_fire = aw_have && w_have && !s_axi_bvalid;
  assign w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_have <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      w_have <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have <= 1'b0;
    end
  end

  always_comb begin
    wr_ok = (aw_addr == OFF_PCLR) || (aw_addr == OFF_IRQ_STAT) || (aw_addr == OFF_IRQ_EN)
            || (aw_addr == OFF_IRQ_CLR);
    for (int i = 0; i < NUM_CH; i++) begin
      if (aw_addr[ADDR_W-1:4] == 2'(i) && aw_addr[1:0] == 2'h0) begin
        wr_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Channel settings
  // ----------------------------------------
  // Each channel has its own bank, and a larger delay is clamped rather than refused.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_req <= {NUM_CH{REQ_RST}};
      ctrl_dly_en <= {NUM_CH{DLY_EN_RST}};
      rise_ms <= {NUM_CH{DELAY_RST}};
      fall_ms <= {NUM_CH{DELAY_RST}};
    end else if (wr_fire) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (aw_addr == ADDR_W'(i * 16) + OFF_CTRL && w_strb[0]) begin
          ctrl_req[i] <= w_data[CTRL_REQ_BIT];
          ctrl_dly_en[i] <= w_data[CTRL_DLY_EN_BIT];
        end
        if (aw_addr == ADDR_W'(i * 16) + OFF_RISE) begin
          rise_ms[i] <= clamp_ms((rise_ms[i] & ~w_mask[DLY_W-1:0])
                                 | (w_data[DLY_W-1:0] & w_mask[DLY_W-1:0]));
        end
        if (aw_addr == ADDR_W'(i * 16) + OFF_FALL) begin
          fall_ms[i] <= clamp_ms((fall_ms[i] & ~w_mask[DLY_W-1:0])
                                 | (w_data[DLY_W-1:0] & w_mask[DLY_W-1:0]));
        end
      end
    end
  end

  function automatic logic [DLY_W-1:0] clamp_ms(input logic [DLY_W-1:0] v);
    clamp_ms = (v > DELAY_MAX) ? DELAY_MAX : v;
  endfunction : clamp_ms

  // Channel field 0 means no channel given and selects the first one; 3 is ignored.
  assign pclr_hit = wr_fire && aw_addr == OFF_PCLR && w_strb[0] && w_data[1:0] != 2'h3;
  assign pclr_idx = (w_data[1:0] == 2'h2);

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign prot_clr[c] = pclr_hit && (pclr_idx == 1'(c));

    odp_ms_tick #(
      .CYC(TICK_CYC)
    ) u_tick (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .restart(ms_restart[c]),
      .tick(ms_tick[c])
    );

    odp_chan u_chan (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .want_on(ctrl_req[c]),
      .dly_en(ctrl_dly_en[c]),
      .rise_ms(rise_ms[c]),
      .fall_ms(fall_ms[c]),
      .tick(ms_tick[c]),
      .restart(ms_restart[c]),
      .trip(trip_sync[c*FAULT_W +: FAULT_W]),
      .prot_clr(prot_clr[c]),
      .flags(flags[c]),
      .qsum(qsum[c]),
      .trip_code(trip_code[c]),
      .trip_evt(trip_evt[c]),
      .out_on(chan_out[c]),
      .busy(busy[c]),
      .switch_evt(switch_evt[c])
    );
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_evt = {switch_evt, trip_evt};
  assign irq_clr = (wr_fire && aw_addr == OFF_IRQ_CLR) ? (w_data[IRQ_W-1:0] & w_mask[IRQ_W-1:0])
                                                       : '0;

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_en <= IRQ_EN_RST;
    end else if (wr_fire && aw_addr == OFF_IRQ_EN && w_strb[0]) begin
      irq_en <= w_data[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_PCLR: rd_word = '0;
      OFF_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat;
      OFF_IRQ_EN: rd_word[IRQ_W-1:0] = irq_en;
      OFF_IRQ_CLR: rd_word = '0;
      default: rd_ok = 1'b0;
    endcase
    for (int i = 0; i < NUM_CH; i++) begin
      if (s_axi_araddr == ADDR_W'(i * 16) + OFF_CTRL) begin
        rd_ok = 1'b1;
        rd_word[CTRL_REQ_BIT] = ctrl_req[i];
        rd_word[CTRL_DLY_EN_BIT] = ctrl_dly_en[i];
      end
      if (s_axi_araddr == ADDR_W'(i * 16) + OFF_RISE) begin
        rd_ok = 1'b1;
        rd_word[DLY_W-1:0] = rise_ms[i];
      end
      if (s_axi_araddr == ADDR_W'(i * 16) + OFF_FALL) begin
        rd_ok = 1'b1;
        rd_word[DLY_W-1:0] = fall_ms[i];
      end
      if (s_axi_araddr == ADDR_W'(i * 16) + OFF_STAT) begin
        rd_ok = 1'b1;
        rd_word[FAULT_W-1:0] = flags[i];
        rd_word[STAT_QSUM_BIT] = qsum[i];
        rd_word[STAT_OUT_BIT] = chan_out[i];
        rd_word[STAT_BUSY_BIT] = busy[i];
        rd_word[STAT_CODE_LSB +: 3] = trip_code[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : odp_top
`default_nettype wire

// ==== verif/odp_top_props.sv ====
// Concurrent checks on the ports of the output delay and protection block.
`timescale 1ns/1ps
`default_nettype none
module odp_top_props
  import odp_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Fault pins and outputs.
  input wire logic [NUM_CH-1:0] over_current_trip,
  input wire logic [NUM_CH-1:0] reversed_sense_fault,
  input wire logic [NUM_CH-1:0] chan_out,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Protection
  // ----------------------------------------
  // Four samples cover two synchroniser stages, the latch and the output flop.
  oc_forces_off_a: assert property (over_current_trip[0] [*4] |=> !chan_out[0])
    else $error("output still on after over current");
  rvs_forces_off_a: assert property (reversed_sense_fault[1] [*4] |=> !chan_out[1])
    else $error("output still on after reversed sense");
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  write_answer_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) |-> ##2 s_axi_bvalid) else $error("write response missing");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read data missing");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr >= 6'h30 |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  clear_reads_zero_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == OFF_PCLR |=> s_axi_rresp == AXI_OKAY && s_axi_rdata == 32'h0)
    else $error("clear register read not zero");
  cover property ($rose(chan_out[0]));
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == AXI_SLVERR);
endmodule : odp_top_props

bind odp_top odp_top_props #(.TICK_CYC(TICK_CYC)) u_props (.mclk(mclk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .over_current_trip(over_current_trip), .reversed_sense_fault(reversed_sense_fault),
  .chan_out(chan_out), .irq(irq));
`default_nettype wire

// ==== verif/tb_odp_top.sv ====
// Self-checking testbench for the output delay and protection block.
`timescale 1ns/1ps
`default_nettype none
module tb_odp_top;
  import odp_pkg::*;
  // A short tick keeps millisecond delays to a few cycles each.
  localparam int TC = 4;
  logic mclk, sys_rst, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [NUM_CH-1:0] chan_out;
  logic [NUM_CH-1:0] flt [FAULT_W];
  int num_errors, total_checks, cnt;
  odp_top #(.TICK_CYC(TC)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .over_current_trip(flt[FLT_OC]), .over_voltage_trip(flt[FLT_OV]),
    .over_temp_trip(flt[FLT_OT]), .reversed_sense_fault(flt[FLT_RVS]),
    .open_sense_fault(flt[FLT_OPS]), .chan_out(chan_out), .irq(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // Requests change only just after a rising edge, and every answer is read at the edge
  // that takes it, so a late start can never leave a valid up for a second transfer.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) num_errors++;
    @(posedge mclk);
  endtask : wr
  task automatic rdr(input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) num_errors++;
    @(posedge mclk);
  endtask : rdr
  task automatic meas(input int ch, input logic lvl);
    cnt = 0;
    while (chan_out[ch] !== lvl && cnt < 300) begin
      @(posedge mclk);
      cnt++;
    end
  endtask : meas
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    for (int i = 0; i < FAULT_W; i++) flt[i] = '0;
    num_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rdr(CH_STRIDE + OFF_CTRL);
    chk("ctrl reset", rd, 32'h0);
    rdr(OFF_RISE);
    chk("rise reset", rd, 32'h0);
    rdr(CH_STRIDE + OFF_STAT);
    chk("stat reset", rd, 32'h0);
    wr(CH_STRIDE + OFF_RISE, 32'h0000_3fff);
    rdr(CH_STRIDE + OFF_RISE);
    chk("rise clamp", rd, 32'h0000_2710);
    $display("test reset and limits done");
    wr(OFF_CTRL, 32'h1);
    meas(0, 1'b1);
    chk("no delay on", 32'(cnt <= 3), 32'h1);
    chk("other channel", 32'(chan_out[1]), 32'h0);
    wr(OFF_RISE, 32'h3);
    wr(OFF_FALL, 32'h5);
    wr(OFF_CTRL, 32'h2);
    meas(0, 1'b0);
    chk("fall delay", 32'(cnt >= 18 && cnt <= 24), 32'h1);
    wr(OFF_CTRL, 32'h3);
    meas(0, 1'b1);
    chk("rise delay", 32'(cnt >= 10 && cnt <= 16), 32'h1);
    wr(OFF_CTRL, 32'h2);
    repeat (8) @(posedge mclk);
    wr(OFF_CTRL, 32'h3);
    cnt = 0;
    repeat (30) begin
      @(posedge mclk);
      if (chan_out[0] !== 1'b1) cnt++;
    end
    chk("restart kept on", 32'(cnt), 32'h0);
    $display("test delays done");
    wr(OFF_IRQ_EN, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    flt[FLT_OC][0] <= 1'b1;
    repeat (6) @(posedge mclk);
    flt[FLT_OC][0] <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("fault off", 32'(chan_out[0]), 32'h0);
    chk("irq raised", 32'(irq), 32'h1);
    rdr(OFF_STAT);
    chk("oc stat", rd & 32'hffff_fdff, 32'h0001_0081);
    wr(OFF_IRQ_CLR, 32'h1);
    repeat (3) @(posedge mclk);
    chk("irq cleared", 32'(irq), 32'h0);
    wr(OFF_PCLR, 32'h0);
    rdr(OFF_STAT);
    chk("ch1 cleared", rd & 32'h0007_00ff, 32'h0);
    meas(0, 1'b1);
    chk("rise after clear", 32'(cnt >= 6 && cnt <= 20), 32'h1);
    rdr(OFF_PCLR);
    chk("clear reads", rd, 32'h0);
    wr(CH_STRIDE + OFF_CTRL, 32'h1);
    for (int i = 0; i < FAULT_W; i++) begin
      chk("ch2 on", 32'(chan_out[1]), 32'h1);
      flt[i][1] <= 1'b1;
      repeat (6) @(posedge mclk);
      flt[i][1] <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("ch2 forced off", 32'(chan_out[1]), 32'h0);
      rdr(CH_STRIDE + OFF_STAT);
      chk("flags", 32'(rd[4:0]), 32'(1 << i));
      chk("summary", 32'(rd[7]), 32'(i < 4));
      chk("trip code", 32'(rd[18:16]), 32'(i + 1));
      chk("ch1 stays on", 32'(chan_out[0]), 32'h1);
      wr(OFF_PCLR, 32'h3);
      rdr(CH_STRIDE + OFF_STAT);
      chk("ignored clear", 32'(rd[4:0]), 32'(1 << i));
      wr(OFF_PCLR, 32'h2);
      rdr(CH_STRIDE + OFF_STAT);
      chk("ch2 cleared", rd & 32'h0007_00ff, 32'h0);
    end
    $display("test protection done");
    wr(6'h30, 32'h1);
    chk("unmapped write", 32'(rs), 32'(AXI_SLVERR));
    rdr(6'h3c);
    chk("unmapped read", {rd[29:0], rs}, 32'(AXI_SLVERR));
    $display("test unmapped done");
    conclude();
  end
endmodule : tb_odp_top
`default_nettype wire
